// ---- common/ramp_pkg.sv ----
// Notes on behaviour
// - Six-bit string-enable field picks active sinks; all six is the default.
// - String-enable field drives the sinks only while auto-detect select is zero.
// - Ramp-time code 00 is immediate; 01, 10, 11 give 50, 100, 200 ms.
// - Ramp moves brightness one LSB per 12.2, 24.4 or 48.8 us step.
// - Ramp duration scales with level difference because the step interval is fixed.
// - Smoothing code selects first-order filter strength; 00 off, 11 heaviest.
// - Smoothing strength also depends on ramp time, giving twelve distinct smoothed behaviours besides off.
// - Frequency strap decodes sixteen boost/PWM frequency pairs; grounded is 500k/9.8k.
// - Current strap gives both boost compensation and full-scale current.
package ramp_pkg;
	localparam logic [7:0] STRING_EN_ADDR = 8'h14;
	localparam logic [7:0] RAMP_CFG_ADDR = 8'h15;
	localparam logic [7:0] STRING_EN_RST = 8'hbf;
	localparam logic [7:0] RAMP_CFG_RST = 8'h00;
	localparam int ENABLE_LSB = 0;
	localparam int ENABLE_W = 6;
	localparam int STEP_LSB = 0;
	localparam int FILTER_LSB = 6;
	localparam int LEVEL_W = 12;
	localparam int FRAC_W = 8;

	localparam int CLK_PERIOD_NS = 20;
	localparam int STEP_50MS_NS = 12200;
	localparam int STEP_100MS_NS = 24400;
	localparam int STEP_200MS_NS = 48800;
	localparam logic [11:0] STEP_50MS_CYC = 12'(STEP_50MS_NS / CLK_PERIOD_NS);
	localparam logic [11:0] STEP_100MS_CYC = 12'(STEP_100MS_NS / CLK_PERIOD_NS);
	localparam logic [11:0] STEP_200MS_CYC = 12'(STEP_200MS_NS / CLK_PERIOD_NS);

	localparam logic [1:0] STEP_IMMEDIATE = 2'h0;
	localparam logic [1:0] FILTER_OFF = 2'h0;

	localparam logic [4:0] STRAP_GROUNDED = 5'h10;
	localparam int STRAP_HIGH_BIT = 3;
	localparam logic [2:0] PWM_FREQ_DEF = 3'h1;
	localparam logic BOOST_FREQ_DEF = 1'b0;
	localparam logic BOOST_COMP_DEF = 1'b1;
	localparam logic [2:0] FULL_SCALE_DEF = 3'h7;
	localparam logic [2:0] FULL_SCALE_GND = 3'h5;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage

// ---- core/ramp_smoother.sv ----
module ramp_smoother
	import ramp_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic en, // Filter update enable
	input wire logic [3:0] shift, // Filter strength as a right shift
	input wire logic [LEVEL_W-1:0] x, // Unfiltered level
	output logic [LEVEL_W-1:0] y // Filtered level
);
	localparam int ACC_W = LEVEL_W + FRAC_W;

	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_d;
	logic signed [ACC_W:0] diff;
	logic signed [ACC_W:0] delta;

	// Taking the whole difference when the shifted step is zero keeps small differences from stalling the filter short of target
	always_comb begin
		diff = $signed({1'b0, x, {FRAC_W{1'b0}}}) - $signed({1'b0, acc_q});
		delta = diff >>> shift;
		if (delta == '0 && diff != '0)
			delta = diff;
		acc_d = acc_q;
		if (en)
			acc_d = ACC_W'($signed({1'b0, acc_q}) + delta);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			acc_q <= '0;
		else
			acc_q <= acc_d;
	end

	assign y = acc_q[ACC_W-1:FRAC_W];
endmodule // ramp_smoother

// ---- core/backlight_ramp.sv ----
module backlight_ramp
	import ramp_pkg::*;
(
	input wire logic clk, // System clock, 50 MHz
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic [7:0] reg_addr, // Register address from serial engine
	input wire logic [7:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Register write strobe, one cycle
	input wire logic reg_rd, // Register read strobe, one cycle
	output logic [7:0] reg_rdata, // Register read data
	input wire logic auto_detect_sel, // String auto-detect selected
	input wire logic [5:0] detected_strings, // Strings found by auto-detect
	input wire logic [LEVEL_W-1:0] brightness_target, // Requested level
	input wire logic strapped_variant, // Pin: strap-configured variant
	input wire logic [4:0] frequency_strap_pin, // Pin: frequency strap code
	input wire logic [4:0] current_strap_pin, // Pin: current strap code
	output logic [5:0] sink_enable, // Active current sinks
	output logic [LEVEL_W-1:0] brightness_out, // Ramped, smoothed level
	output logic ramp_active, // Ramp not yet at target
	output logic boost_freq_1mhz, // Boost at 1000 kHz when high
	output logic [2:0] pwm_freq_sel, // PWM output frequency code
	output logic boost_comp, // Boost compensation option
	output logic [2:0] full_scale_sel // Full-scale current code
);
	// Register file
	logic [7:0] string_en_q, string_en_d;
	logic [7:0] ramp_cfg_q, ramp_cfg_d;
	logic [7:0] rdata_q, rdata_d;

	always_comb begin
		string_en_d = string_en_q;
		ramp_cfg_d = ramp_cfg_q;
		rdata_d = rdata_q;
		if (reg_wr) begin
			if (reg_addr == STRING_EN_ADDR)
				string_en_d = reg_wdata;
			if (reg_addr == RAMP_CFG_ADDR)
				ramp_cfg_d = reg_wdata;
		end
		if (reg_rd) begin
			case (reg_addr)
				STRING_EN_ADDR: rdata_d = string_en_q;
				RAMP_CFG_ADDR: rdata_d = ramp_cfg_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Defaults return only through reset; the host must restore its settings
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			string_en_q <= STRING_EN_RST;
			ramp_cfg_q <= RAMP_CFG_RST;
			rdata_q <= 8'h00;
		end else begin
			string_en_q <= string_en_d;
			ramp_cfg_q <= ramp_cfg_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	logic [1:0] step_code;
	logic [1:0] filter_code;
	assign step_code = ramp_cfg_q[STEP_LSB +: 2];
	assign filter_code = ramp_cfg_q[FILTER_LSB +: 2];

	// String enables
	logic [5:0] sink_q, sink_d;

	always_comb begin
		if (auto_detect_sel)
			sink_d = detected_strings;
		else
			sink_d = string_en_q[ENABLE_LSB +: ENABLE_W];
	end

	// Step interval divider
	logic [11:0] div_q, div_d;
	logic [11:0] div_limit;
	logic step_tick;

	always_comb begin
		case (step_code)
			2'h1: div_limit = STEP_50MS_CYC;
			2'h2: div_limit = STEP_100MS_CYC;
			2'h3: div_limit = STEP_200MS_CYC;
			default: div_limit = 12'h001;
		endcase
		step_tick = (div_q >= div_limit - 12'h001);
		div_d = step_tick ? 12'h000 : div_q + 12'h001;
	end

	// Linear ramp: fixed step time, so duration follows the level difference
	logic [LEVEL_W-1:0] ramp_q, ramp_d;

	always_comb begin
		ramp_d = ramp_q;
		if (step_code == STEP_IMMEDIATE)
			ramp_d = brightness_target;
		else if (step_tick) begin
			if (ramp_q < brightness_target)
				ramp_d = ramp_q + 12'h001;
			else if (ramp_q > brightness_target)
				ramp_d = ramp_q - 12'h001;
		end
	end

	// Smoothing strength grows with ramp time as well as with the code
	logic [3:0] filt_shift;
	logic filt_en;
	logic [LEVEL_W-1:0] filt_y;

	always_comb begin
		filt_shift = {2'b00, filter_code} + {2'b00, step_code};
		filt_en = (step_code == STEP_IMMEDIATE) | step_tick;
	end

	ramp_smoother u_smoother (
		.clk(clk),
		.rstn(rstn),
		.en(filt_en),
		.shift(filt_shift),
		.x(ramp_q),
		.y(filt_y)
	);

	logic [LEVEL_W-1:0] bright_q, bright_d;
	logic active_q, active_d;

	always_comb begin
		if (filter_code == FILTER_OFF)
			bright_d = ramp_q;
		else
			bright_d = filt_y;
		active_d = (ramp_q != brightness_target);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sink_q <= 6'h00;
			div_q <= 12'h000;
			ramp_q <= '0;
			bright_q <= '0;
			active_q <= 1'b0;
		end else begin
			sink_q <= sink_d;
			div_q <= div_d;
			ramp_q <= ramp_d;
			bright_q <= bright_d;
			active_q <= active_d;
		end
	end

	assign sink_enable = sink_q;
	assign brightness_out = bright_q;
	assign ramp_active = active_q;

	// Strap pins come from outside the clock domain; two flops each
	logic [10:0] strap_meta_q, strap_sync_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strap_meta_q <= 11'h000;
			strap_sync_q <= 11'h000;
		end else begin
			strap_meta_q <= {strapped_variant, frequency_strap_pin, current_strap_pin};
			strap_sync_q <= strap_meta_q;
		end
	end

	logic sync_variant;
	logic [4:0] sync_fcode, sync_icode;
	assign sync_variant = strap_sync_q[10];
	assign sync_fcode = strap_sync_q[9:5];
	assign sync_icode = strap_sync_q[4:0];

	// Straps are read once after reset; a resistor change needs another reset
	logic [1:0] settle_q, settle_d;
	logic latch_now;
	logic bfreq_q, bfreq_d;
	logic [2:0] pfreq_q, pfreq_d;
	logic bcomp_q, bcomp_d;
	logic [2:0] fscale_q, fscale_d;

	always_comb begin
		settle_d = settle_q;
		latch_now = 1'b0;
		if (settle_q != STRAP_SETTLE)
			settle_d = settle_q + 2'h1;
		if (settle_q == STRAP_SETTLE - 2'h1)
			latch_now = 1'b1;
		bfreq_d = bfreq_q;
		pfreq_d = pfreq_q;
		bcomp_d = bcomp_q;
		fscale_d = fscale_q;
		if (latch_now && sync_variant) begin
			if (sync_fcode[4]) begin
				bfreq_d = BOOST_FREQ_DEF;
				pfreq_d = PWM_FREQ_DEF;
			end else begin
				bfreq_d = sync_fcode[STRAP_HIGH_BIT];
				pfreq_d = sync_fcode[2:0];
			end
			if (sync_icode[4]) begin
				bcomp_d = BOOST_COMP_DEF;
				fscale_d = FULL_SCALE_GND;
			end else begin
				bcomp_d = ~sync_icode[STRAP_HIGH_BIT];
				fscale_d = sync_icode[2:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			settle_q <= 2'h0;
			bfreq_q <= BOOST_FREQ_DEF;
			pfreq_q <= PWM_FREQ_DEF;
			bcomp_q <= BOOST_COMP_DEF;
			fscale_q <= FULL_SCALE_DEF;
		end else begin
			settle_q <= settle_d;
			bfreq_q <= bfreq_d;
			pfreq_q <= pfreq_d;
			bcomp_q <= bcomp_d;
			fscale_q <= fscale_d;
		end
	end

	assign boost_freq_1mhz = bfreq_q;
	assign pwm_freq_sel = pfreq_q;
	assign boost_comp = bcomp_q;
	assign full_scale_sel = fscale_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_sink_select: assert property (
		1'b1 |=> sink_enable == ($past(auto_detect_sel) ? $past(detected_strings)
			: $past(string_en_q[5:0])))
		else $error("sink enables do not follow selection");

	a_step_one_lsb: assert property (
		(step_code != STEP_IMMEDIATE && step_tick && ramp_q != brightness_target)
		|=> (ramp_q == $past(ramp_q) + 12'h001) || (ramp_q == $past(ramp_q) - 12'h001))
		else $error("ramp step is not one LSB");

	a_step_spacing: assert property (
		(step_tick && step_code == 2'h1 && $stable(step_code)) |=> !step_tick [*8])
		else $error("step ticks too close together");

	a_ramp_immediate: assert property (
		step_code == STEP_IMMEDIATE |=> ramp_q == $past(brightness_target))
		else $error("immediate code did not jump to target");

	a_ramp_hold: assert property (
		(ramp_q == brightness_target && $stable(brightness_target)) |=> $stable(ramp_q))
		else $error("ramp moved while at target");

	a_filter_bypass: assert property (
		filter_code == FILTER_OFF |=> brightness_out == $past(ramp_q))
		else $error("unsmoothed output differs from ramp");

	a_filter_tailor: assert property (
		(filter_code != FILTER_OFF) |-> filt_shift > {2'b00, step_code})
		else $error("smoothing strength not tied to ramp time");

	// Outside the immediate code the filter only moves on step ticks, so its time constant scales with the ramp time
	a_filter_pace: assert property (
		(filter_code != FILTER_OFF && step_code != STEP_IMMEDIATE && !step_tick)
		|=> $stable(filt_y))
		else $error("smoothing updated off the step rate");

	a_freq_strap: assert property (
		(latch_now && sync_variant && !sync_fcode[4])
		|=> boost_freq_1mhz == $past(sync_fcode[3]) && pwm_freq_sel == $past(sync_fcode[2:0]))
		else $error("frequency strap decoded wrongly");

	a_current_strap: assert property (
		(latch_now && sync_variant && sync_icode[4])
		|=> boost_comp == BOOST_COMP_DEF && full_scale_sel == FULL_SCALE_GND)
		else $error("grounded current strap decoded wrongly");

	c_ramp_up: cover property (step_code == 2'h2 && step_tick && ramp_q < brightness_target);
	c_smoothed: cover property (filter_code == 2'h3 && step_code == 2'h3 && filt_en);
	c_auto_sel: cover property (auto_detect_sel && sink_enable != string_en_q[5:0]);
	c_strapped: cover property (latch_now && sync_variant);
endmodule // backlight_ramp

// ---- tb/host_model.sv ----
module host_model (
	input wire logic clk, // System clock
	output logic [7:0] reg_addr, // Register address
	output logic [7:0] reg_wdata, // Write data
	output logic reg_wr, // Write strobe
	output logic reg_rd, // Read strobe
	input wire logic [7:0] reg_rdata // Read data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Settings are lost at reset, so callers rewrite the ones a test relies on after a reset
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// Released lines show a changed value so stale data is never read as valid
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule // host_model

// ---- tb/tb.sv ----
module tb
	import ramp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, reg_wr, reg_rd, auto_detect_sel, strapped_variant;
	logic ramp_active, boost_freq_1mhz, boost_comp;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic [5:0] detected_strings, sink_enable;
	logic [11:0] brightness_target, brightness_out;
	logic [4:0] frequency_strap_pin, current_strap_pin;
	logic [2:0] pwm_freq_sel, full_scale_sel;
	logic [7:0] straps;
	assign straps = {boost_freq_1mhz, pwm_freq_sel, boost_comp, full_scale_sel};
	int bad_count = 0;
	int samples_checked = 0;
	backlight_ramp DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.auto_detect_sel(auto_detect_sel), .detected_strings(detected_strings),
		.brightness_target(brightness_target), .strapped_variant(strapped_variant),
		.frequency_strap_pin(frequency_strap_pin), .current_strap_pin(current_strap_pin),
		.sink_enable(sink_enable), .brightness_out(brightness_out), .ramp_active(ramp_active),
		.boost_freq_1mhz(boost_freq_1mhz), .pwm_freq_sel(pwm_freq_sel),
		.boost_comp(boost_comp), .full_scale_sel(full_scale_sel));
	host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic do_reset(input logic sv, input logic [4:0] f, input logic [4:0] c);
		@(negedge clk);
		rstn = 1'b0;
		strapped_variant = sv;
		frequency_strap_pin = f;
		current_strap_pin = c;
		brightness_target = 12'h000;
		cyc(4);
		rstn = 1'b1;
	endtask
	task automatic t_regs;
		host.rd(8'h14, rv);
		chk("enable reg", 12'(STRING_EN_RST), 12'(rv));
		host.rd(8'h15, rv);
		chk("ramp reg", 12'(RAMP_CFG_RST), 12'(rv));
		chk("sinks", 12'h03f, 12'(sink_enable));
		chk("straps off", 12'h01f, 12'(straps));
		host.rd(8'h16, rv);
		chk("unmapped", 12'h000, 12'(rv));
		$display("test regs done");
	endtask
	task automatic t_sinks;
		logic [5:0] codes [5] = '{6'h01, 6'h0f, 6'h1f, 6'h3f, 6'h2a};
		foreach (codes[i]) begin
			host.wr(8'h14, {2'b10, codes[i]});
			cyc(2);
			chk("sinks", 12'(codes[i]), 12'(sink_enable));
		end
		host.rd(8'h14, rv);
		chk("enable readback", 12'h0aa, 12'(rv));
		detected_strings = 6'h15;
		auto_detect_sel = 1'b1;
		cyc(2);
		chk("auto sinks", 12'h015, 12'(sink_enable));
		auto_detect_sel = 1'b0;
		cyc(2);
		chk("manual sinks", 12'h02a, 12'(sink_enable));
		$display("test sinks done");
	endtask
	task automatic t_filter_strength;
		host.wr(8'h15, 8'hc0);
		brightness_target = 12'h800;
		cyc(4);
		// Heavy filtering must leave the output part way after a few updates
		chk("smoothed", 12'h001, 12'(brightness_out > 0 && brightness_out < 12'h800));
		// Shift of three: one eighth of the gap per update, output one edge behind
		chk("smoothed level", 12'h1e0, brightness_out);
		$display("test filter_strength done");
	endtask
	task automatic t_immediate;
		host.wr(8'h15, 8'h00);
		brightness_target = 12'h123;
		cyc(2);
		chk("immediate", 12'h123, brightness_out);
		$display("test immediate done");
	endtask
	task automatic t_ramp;
		int n;
		logic [11:0] v;
		for (int c = 1; c < 4; c++) begin
			host.wr(8'h15, 8'(c));
			v = brightness_out;
			brightness_target = v + 12'h002;
			n = 0;
			while (brightness_out === v && n < 3000) begin
				cyc(1);
				n++;
			end
			chk("ramp active", 12'h001, 12'(ramp_active));
			n = 0;
			while (brightness_out === v + 12'h001 && n < 3000) begin
				cyc(1);
				n++;
			end
			chk("step interval", 12'(610 << (c - 1)), 12'(n));
			chk("ramp end", v + 12'h002, brightness_out);
			cyc(3);
			chk("ramp idle", 12'h000, 12'(ramp_active));
		end
		$display("test ramp done");
	endtask
	task automatic t_strap(input logic [4:0] f, input logic [4:0] c, input logic [7:0] e);
		do_reset(1'b1, f, c);
		cyc(6);
		chk("straps", 12'(e), 12'(straps));
		$display("test strap done");
	endtask
	// Light smoothing at the 50 ms ramp: shift two, filter updates only on step ticks
	task automatic t_tailor;
		do_reset(1'b0, 5'h00, 5'h00);
		host.wr(8'h15, 8'h41);
		brightness_target = 12'h004;
		cyc(2440);
		chk("lagging", 12'h000, brightness_out);
		cyc(1);
		chk("lag at end", 12'h001, brightness_out);
		chk("ramp done", 12'h000, 12'(ramp_active));
		$display("test tailor done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		rstn = 1'b0;
		auto_detect_sel = 1'b0;
		detected_strings = 6'h00;
		do_reset(1'b0, 5'h00, 5'h00);
		t_regs();
		t_sinks();
		t_filter_strength();
		do_reset(1'b0, 5'h00, 5'h00);
		t_immediate();
		t_ramp();
		t_tailor();
		t_strap(5'h10, 5'h10, 8'h1d);
		t_strap(5'h08, 5'h0f, 8'h87);
		final_report();
	end
	// Whole run is about 11k cycles; the limit leaves ample margin
	initial begin
		#400000;
		bad_count++;
		final_report();
	end
endmodule // tb
